/* File: radio_control_config_regs_test.sv */
// self-checking bench of the radio control registers and sequencing
// assumes rcc_top, rcc_host and rcc_chk compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "rcc_consts.svh"
module radio_control_config_regs_test;
  import rcc_pkg::*;
  localparam int RB = 2;
  logic REF_CLK_I = 1'b0;
  logic NRST_I = 1'b0;
  logic TX_START_I = 1'b0, SYNTH_ON_I = 1'b0, IDLE_I = 1'b0, CALIBRATE_STROBE_I = 1'b0;
  logic PKT_DONE_I = 1'b0, CAL_DONE_I = 1'b0, SLEEP_I = 1'b0, CRYSTAL_OSCILLATOR_STABLE_I = 1'b1;
  logic [7:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
  logic [3:0] S_AXI_WSTRB_I;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, TX_SYNC_O, SYNC_QUAL_O;
  logic S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O, S_AXI_BVALID_O;
  logic S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I;
  logic CAL_START_O, PREAMBLE_START_O, CHIP_READY_N_O, SYNC_CS_EN_O;
  logic [2:0] STATE_O;
  logic [19:0] CHANNEL_OFFSET_O;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] m, c;
  logic [1:0] e;
  int seed = 34;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_cal = 0;
  int n_pre = 0;
  int tc, n;
  int exp_n[4] = '{1, 16, 64, 256};
  always #4 REF_CLK_I = ~REF_CLK_I;
  rcc_host host_u (.*);
  rcc_top #(.RIPPLE_BITS(RB)) dut_u (.*);
  function automatic logic [4:0] exp_sync(input logic [2:0] s);
    return {s[1:0], s[2], (s[1:0] == 2'h0) ? 2'h0 : (s[1:0] == 2'h3) ? 2'h2 : 2'h1};
  endfunction
  function automatic logic [19:0] exp_off(input logic [7:0] mm, cc, input logic [1:0] ee);
    logic [19:0] v;
    v = (20'h0_0100 + mm) * cc;
    return v << ee;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdchk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
    host_u.rd(idx, d, r);
    chk(nm, d, exp);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    host_u.wr(idx, v, r);
    chk("bresp", r, `RCC_RESP_OKAY);
  endtask
  task automatic settle();
    repeat (2) @(posedge REF_CLK_I);
    #1;
  endtask
  // one-cycle strobe: 0 tx, 1 synth, 2 idle, 3 cal, 4 packet end, 5 cal done
  task automatic pulse(input int k);
    @(posedge REF_CLK_I);
    {CAL_DONE_I, PKT_DONE_I, CALIBRATE_STROBE_I, IDLE_I, SYNTH_ON_I, TX_START_I} <= 6'h01 << k;
    @(posedge REF_CLK_I);
    {CAL_DONE_I, PKT_DONE_I, CALIBRATE_STROBE_I, IDLE_I, SYNTH_ON_I, TX_START_I} <= 6'h00;
    settle();
  endtask
  always @(posedge REF_CLK_I)
  begin
    cyc <= cyc + 1;
    n_cal <= n_cal + (CAL_START_O === 1'b1);
    n_pre <= n_pre + (PREAMBLE_START_O === 1'b1);
    if (cyc == 30000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge REF_CLK_I);
    NRST_I <= 1'b1;
    settle();
    rdchk("mant", `RCC_IDX_MANT, 32'h0000_00F8);
    rdchk("aftx", `RCC_IDX_AFTX, 32'h0000_0000);
    rdchk("calpwr", `RCC_IDX_CALPWR, 32'h0000_0008);
    chk("sync rst", {SYNC_QUAL_O, SYNC_CS_EN_O, TX_SYNC_O}, exp_sync(3'h2));
    host_u.rd(6'h01, d, r);
    chk("unmapped", {r, d[29:0]}, {`RCC_RESP_SLVERR, 30'h0});
    host_u.wr(6'h01, 8'h5A, r);
    chk("unmapped wr", r, `RCC_RESP_SLVERR);
    wr(`RCC_IDX_AFTX, 8'hFF);
    rdchk("aftx rsvd", `RCC_IDX_AFTX, 32'h0000_0000);
    wr(`RCC_IDX_CALPWR, 8'hFF);
    rdchk("calpwr rsvd", `RCC_IDX_CALPWR, 32'h0000_003C);
    $display("test registers done");
    for (int s = 0; s < 8; s++)
    begin
      wr(`RCC_IDX_SYNC, 8'(s));
      settle();
      chk("sync", {SYNC_QUAL_O, SYNC_CS_EN_O, TX_SYNC_O}, exp_sync(3'(s)));
    end
    for (int i = 0; i < 10; i++)
    begin
      m = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      c = (i == 0) ? 8'hFF : 8'($random(seed));
      e = (i == 0) ? 2'h3 : 2'($random(seed));
      wr(`RCC_IDX_CHANNEL_NUMBER, c);
      wr(`RCC_IDX_MANT, m);
      wr(`RCC_IDX_MODEM, {6'h00, e});
      settle();
      chk("offset", CHANNEL_OFFSET_O, exp_off(m, c, e));
    end
    $display("test sync and spacing done");
    wr(`RCC_IDX_CALPWR, 8'h18);
    pulse(0);
    chk("cal on tx", STATE_O, RCC_ST_CAL);
    pulse(5);
    chk("tx", STATE_O, RCC_ST_TX);
    wr(`RCC_IDX_AFTX, 8'h02);
    pulse(4);
    chk("stay tx", STATE_O, RCC_ST_TX);
    chk("preamble", n_pre, 1);
    wr(`RCC_IDX_AFTX, 8'h01);
    pulse(4);
    chk("synth on", STATE_O, RCC_ST_SYNTH_ON);
    pulse(2);
    pulse(1);
    chk("cal on synth", STATE_O, RCC_ST_CAL);
    pulse(5);
    chk("cal count", n_cal, 2);
    pulse(2);
    wr(`RCC_IDX_CALPWR, 8'h08);
    wr(`RCC_IDX_AFTX, 8'h00);
    pulse(0);
    chk("no autocal", STATE_O, RCC_ST_TX);
    pulse(4);
    chk("idle", STATE_O, RCC_ST_IDLE);
    pulse(3);
    chk("manual cal", STATE_O, RCC_ST_CAL);
    pulse(5);
    tc = 1;
    for (int k = 0; k < 10; k++)
    begin
      wr(`RCC_IDX_CALPWR, (k < 4) ? 8'h28 : 8'h38);
      pulse(0);
      pulse(2);
      chk("tx end", STATE_O, (k < 4 || tc == 3) ? RCC_ST_CAL : RCC_ST_IDLE);
      if (STATE_O === RCC_ST_CAL) pulse(5);
      tc = (tc + 1) % 4;
    end
    $display("test sequencing done");
    for (int w = 0; w < 4; w++)
    begin
      wr(`RCC_IDX_CALPWR, 8'(w << 2));
      CRYSTAL_OSCILLATOR_STABLE_I <= 1'b0;
      settle();
      chk("not ready", CHIP_READY_N_O, 1'b1);
      @(posedge REF_CLK_I);
      CRYSTAL_OSCILLATOR_STABLE_I <= 1'b1;
      n = 0;
      while (CHIP_READY_N_O !== 1'b0 && n < 2000)
      begin
        @(posedge REF_CLK_I);
        n++;
      end
      chk("wait", n >= exp_n[w] << RB && n <= (exp_n[w] << RB) + 4, 1'b1);
    end
    wr(`RCC_IDX_MANT, 8'h11);
    SLEEP_I <= 1'b1;
    settle();
    settle();
    chk("sleep", STATE_O, RCC_ST_SLEEP);
    chk("sleep ready", CHIP_READY_N_O, 1'b1);
    @(posedge REF_CLK_I);
    SLEEP_I <= 1'b0;
    settle();
    rdchk("wait kept", `RCC_IDX_CALPWR, 32'h0000_000C);
    rdchk("mant lost", `RCC_IDX_MANT, 32'h0000_00F8);
    rdchk("status", `RCC_IDX_STATUS, {26'h0, 2'(tc), 4'h0});
    $display("test power-up done");
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: rcc_chk.sv */
// port assertions of the radio control block
// assumes binding into rcc_top by port names
`timescale 1ns/100ps
`default_nettype none
`include "rcc_consts.svh"
module rcc_chk
  import rcc_pkg::*;
#(
  parameter int RIPPLE_BITS = `RCC_RIPPLE_BITS
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // bus and strobes
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic PKT_DONE_I,
  input wire logic CAL_DONE_I,
  input wire logic CRYSTAL_OSCILLATOR_STABLE_I,
  // radio outputs
  input wire rcc_pkg::rcc_state_t STATE_O,
  input wire logic CAL_START_O,
  input wire logic PREAMBLE_START_O,
  input wire logic CHIP_READY_N_O,
  input wire rcc_pkg::rcc_qual_t SYNC_QUAL_O,
  input wire rcc_pkg::rcc_txsync_t TX_SYNC_O
);
  logic [11:0] stab_q;
  // cycles of stable crystal outside sleep
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      stab_q <= '0;
    else if (!CRYSTAL_OSCILLATOR_STABLE_I || STATE_O == RCC_ST_SLEEP)
      stab_q <= '0;
    else if (stab_q != '1)
      stab_q <= stab_q + 12'h001;
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  AST_RDATA_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  AST_SYNC_NONE: assert property (SYNC_QUAL_O == RCC_QUAL_NONE |->
    TX_SYNC_O == RCC_TXSYNC_NONE) else $error("sync sent without qualifier");
  AST_SYNC_SINGLE: assert property (SYNC_QUAL_O inside {RCC_QUAL_15_16, RCC_QUAL_16_16} |->
    TX_SYNC_O == RCC_TXSYNC_SINGLE) else $error("single sync word expected");
  AST_SYNC_REPEAT: assert property (SYNC_QUAL_O == RCC_QUAL_30_32 |->
    TX_SYNC_O == RCC_TXSYNC_REPEAT) else $error("repeated sync word expected");
  AST_PREAMBLE: assert property (PREAMBLE_START_O |->
    STATE_O == RCC_ST_TX && $past(PKT_DONE_I)) else $error("stray preamble start");
  AST_CAL_ENTRY: assert property (CAL_START_O |->
    STATE_O == RCC_ST_CAL) else $error("calibration start outside cal");
  AST_CAL_EXIT: assert property (STATE_O == RCC_ST_CAL && CAL_DONE_I |=>
    STATE_O != RCC_ST_CAL) else $error("cal done ignored");
  AST_PKT_END: assert property (STATE_O == RCC_ST_TX && PKT_DONE_I |=>
    STATE_O != RCC_ST_TX || PREAMBLE_START_O) else $error("packet end ignored");
  AST_READY_WAIT: assert property ($fell(CHIP_READY_N_O) |->
    stab_q >= (12'h001 << RIPPLE_BITS)) else $error("chip ready too early");
  AST_READY_DROP: assert property (!CRYSTAL_OSCILLATOR_STABLE_I |->
    ##[1:2] CHIP_READY_N_O) else $error("chip ready while crystal off");
  cover property (CAL_START_O);
  cover property (PREAMBLE_START_O);
  cover property ($fell(CHIP_READY_N_O));
endmodule
bind rcc_top rcc_chk #(.RIPPLE_BITS(RIPPLE_BITS)) chk_u (.*);
`default_nettype wire

/* File: rcc_consts.svh */
// register offsets, field positions, reset values and timing counts of the radio control block
// assumes an AXI4-Lite slave with word registers; byte address is four times the index
//
// How it works
// - select 1 or 5: fifteen of sixteen bits
// - select 2 or 6: sixteen of sixteen bits
// - select 3 or 7: thirty of thirty-two bits
// - select 4: carrier sense only, no sync
// - transmit sync: none, single or repeated word
// - mantissa has implied leading one, resets 248
// - offset is (256+mantissa) times 2^exp times channel
// - two-bit exponent scales spacing by powers of two
// - after packet: 0 idle, 1 synth on
// - after-transmit 2 stays in transmit, sends preamble
// - autocal 0 manual only, 2 on transmit-to-idle other than packet end with after-transmit 3
// - autocal 1 on idle to transmit or synth
// - autocal 3 every fourth transmit-to-idle return other than packet end with after-transmit 3
// - chip ready low after programmed counter expirations
// - powerup wait count survives sleep
// - reserved bits read as zero
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH

`define RCC_IDX_CHANNEL_NUMBER 6'h0A
`define RCC_IDX_SYNC 6'h12
`define RCC_IDX_MODEM 6'h13
`define RCC_IDX_MANT 6'h14
`define RCC_IDX_AFTX 6'h15
`define RCC_IDX_CALPWR 6'h18
`define RCC_IDX_STATUS 6'h1F

`define RCC_SYNC_LSB 0
`define RCC_EXP_LSB 0
`define RCC_AFTX_LSB 0
`define RCC_AUTOCAL_LSB 4
`define RCC_PWRUP_LSB 2
`define RCC_ST_STATE_LSB 0
`define RCC_ST_READY_BIT 3
`define RCC_ST_CALCNT_LSB 4

`define RCC_RST_CHANNEL_NUMBER 8'h00
`define RCC_RST_SYNC 3'h2
`define RCC_RST_EXP 2'h2
`define RCC_RST_MANT 8'hF8
`define RCC_RST_AFTX 2'h0
`define RCC_RST_AUTOCAL 2'h0
`define RCC_RST_PWRUP 2'h2

`define RCC_RIPPLE_BITS 6
`define RCC_MANT_LEAD 9'h100

`define RCC_RESP_OKAY 2'h0
`define RCC_RESP_SLVERR 2'h2

`endif

/* File: rcc_host.sv */
// host model: axi4-lite master programming the configuration registers
// assumes one slave on the same clock, ports named as the slave's
`timescale 1ns/100ps
`default_nettype none
`include "rcc_consts.svh"
module rcc_host (
  // clock
  input wire logic REF_CLK_I,
  // write
  output var logic [7:0] S_AXI_AWADDR_I,
  output var logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  output var logic [31:0] S_AXI_WDATA_I,
  output var logic [3:0] S_AXI_WSTRB_I,
  output var logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  output var logic S_AXI_BREADY_I,
  // read
  output var logic [7:0] S_AXI_ARADDR_I,
  output var logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  output var logic S_AXI_RREADY_I
);
  initial
  begin
    {S_AXI_AWADDR_I, S_AXI_AWVALID_I, S_AXI_WDATA_I, S_AXI_WSTRB_I} = '0;
    {S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARADDR_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} = '0;
  end
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    // receive transition is never requested
    if (idx == `RCC_IDX_AFTX && d[1:0] == 2'h3) d[1:0] = 2'h0;
    @(posedge REF_CLK_I);
    S_AXI_AWADDR_I <= {idx, 2'h0};
    S_AXI_WDATA_I <= {24'h0, d};
    S_AXI_WSTRB_I <= 4'h1;
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
    while (!(a && w))
    begin
      @(posedge REF_CLK_I);
      a = a || S_AXI_AWREADY_O;
      w = w || S_AXI_WREADY_O;
      S_AXI_AWVALID_I <= !a;
      S_AXI_WVALID_I <= !w;
    end
    do @(posedge REF_CLK_I); while (!S_AXI_BVALID_O);
    r = S_AXI_BRESP_O;
    S_AXI_BREADY_I <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge REF_CLK_I);
    S_AXI_ARADDR_I <= {idx, 2'h0};
    {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'h2;
    do @(posedge REF_CLK_I); while (!S_AXI_ARREADY_O);
    S_AXI_ARVALID_I <= 1'b0;
    // late ready: the slave must hold read data one cycle
    do @(posedge REF_CLK_I); while (!S_AXI_RVALID_O);
    S_AXI_RREADY_I <= 1'b1;
    do @(posedge REF_CLK_I); while (!S_AXI_RVALID_O);
    d = S_AXI_RDATA_O;
    r = S_AXI_RRESP_O;
    S_AXI_RREADY_I <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: rcc_pkg.sv */
// types shared by the radio control block
// assumes nothing beyond the constants header
package rcc_pkg;

  typedef enum logic [2:0] {
    RCC_ST_IDLE = 3'b000,
    RCC_ST_CAL = 3'b001,
    RCC_ST_SYNTH_ON = 3'b010,
    RCC_ST_TX = 3'b011,
    RCC_ST_SLEEP = 3'b100
  } rcc_state_t;

  typedef enum logic [1:0] {
    RCC_QUAL_NONE = 2'b00,
    RCC_QUAL_15_16 = 2'b01,
    RCC_QUAL_16_16 = 2'b10,
    RCC_QUAL_30_32 = 2'b11
  } rcc_qual_t;

  typedef enum logic [1:0] {
    RCC_TXSYNC_NONE = 2'b00,
    RCC_TXSYNC_SINGLE = 2'b01,
    RCC_TXSYNC_REPEAT = 2'b10
  } rcc_txsync_t;

endpackage

/* File: rcc_powerup_timer.sv */
// power-up wait: counts expirations of a ripple counter after the crystal is stable
// assumes osc_ok_i drops whenever the crystal stops
`timescale 1ns/100ps
`default_nettype none
`include "rcc_consts.svh"
module rcc_powerup_timer #(
  parameter int RIPPLE_BITS = `RCC_RIPPLE_BITS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic osc_ok_i,
  input wire logic [1:0] sel_i,
  // status
  output logic done_o
);

  logic [RIPPLE_BITS-1:0] ripple_q;
  logic [8:0] expire_q;
  logic [8:0] target;
  logic wrap;

  always_comb
  begin
    case (sel_i)
      2'h0: target = 9'h001;
      2'h1: target = 9'h010;
      2'h2: target = 9'h040;
      default: target = 9'h100;
    endcase
  end

  assign wrap = &ripple_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ripple_q <= '0;
      expire_q <= 9'h000;
      done_o <= 1'b0;
    end
    else if (!osc_ok_i)
    begin
      ripple_q <= '0;
      expire_q <= 9'h000;
      done_o <= 1'b0;
    end
    else if (!done_o)
    begin
      ripple_q <= ripple_q + 1'b1;
      if (wrap)
      begin
        expire_q <= expire_q + 9'h001;
        done_o <= (expire_q + 9'h001) == target;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rcc_sync_decode.sv */
// decode of the sync qualifier select field
// assumes the caller registers the outputs
`timescale 1ns/100ps
`default_nettype none
module rcc_sync_decode
  import rcc_pkg::*;
(
  // select
  input wire logic [2:0] sel_i,
  // decoded
  output rcc_pkg::rcc_qual_t qual_o,
  output logic cs_en_o,
  output rcc_pkg::rcc_txsync_t txsync_o
);

  always_comb
  begin
    cs_en_o = sel_i[2];
    case (sel_i[1:0])
      2'b01: qual_o = RCC_QUAL_15_16;
      2'b10: qual_o = RCC_QUAL_16_16;
      2'b11: qual_o = RCC_QUAL_30_32;
      default: qual_o = RCC_QUAL_NONE;
    endcase
    case (sel_i[1:0])
      2'b00: txsync_o = RCC_TXSYNC_NONE;
      2'b11: txsync_o = RCC_TXSYNC_REPEAT;
      default: txsync_o = RCC_TXSYNC_SINGLE;
    endcase
  end

endmodule
`default_nettype wire

/* File: rcc_top.sv */
// radio control configuration registers, radio state sequencing and power-up wait
// assumes an AXI4-Lite master and synchronous strobes from the radio core
`timescale 1ns/100ps
`default_nettype none
`include "rcc_consts.svh"
module rcc_top
  import rcc_pkg::*;
#(
  parameter int RIPPLE_BITS = `RCC_RIPPLE_BITS
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // axi write address
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // axi write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // axi write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi read
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // radio core strobes
  input wire logic TX_START_I,
  input wire logic SYNTH_ON_I,
  input wire logic IDLE_I,
  input wire logic CALIBRATE_STROBE_I,
  input wire logic PKT_DONE_I,
  input wire logic CAL_DONE_I,
  input wire logic SLEEP_I,
  input wire logic CRYSTAL_OSCILLATOR_STABLE_I,
  // radio core controls
  output rcc_pkg::rcc_state_t STATE_O,
  output logic CAL_START_O,
  output logic PREAMBLE_START_O,
  output logic CHIP_READY_N_O,
  output logic [19:0] CHANNEL_OFFSET_O,
  output rcc_pkg::rcc_qual_t SYNC_QUAL_O,
  output logic SYNC_CS_EN_O,
  output rcc_pkg::rcc_txsync_t TX_SYNC_O
);

  logic aw_held_q;
  logic [5:0] awidx_q;
  logic w_held_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;
  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic aw_held_d;
  logic w_held_d;
  logic ar_hs;
  logic rvalid_d;
  logic [5:0] aridx;
  logic wr_hit;

  logic [7:0] channel_number_q;
  logic [2:0] sync_sel_q;
  logic [1:0] spacing_exponent_q;
  logic [7:0] spacing_mantissa_q;
  logic [1:0] after_transmit_state_q;
  logic [1:0] auto_cal_select_q;
  logic [1:0] powerup_wait_count_q;

  rcc_state_t state_q;
  rcc_state_t cal_ret_q;
  logic [1:0] tx_idle_cnt_q;
  logic pwr_done;
  rcc_qual_t qual;
  logic cs_en;
  rcc_txsync_t txsync;
  logic cal_on_exit;
  logic [16:0] base_prod;
  logic [19:0] offset;

  assign aw_hs = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  assign w_hs = S_AXI_WVALID_I & S_AXI_WREADY_O;
  assign do_write = aw_held_q & w_held_q & ~S_AXI_BVALID_O;
  assign aw_held_d = (aw_held_q | aw_hs) & ~do_write;
  assign w_held_d = (w_held_q | w_hs) & ~do_write;
  assign ar_hs = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  assign rvalid_d = ar_hs | (S_AXI_RVALID_O & ~S_AXI_RREADY_I);
  assign aridx = S_AXI_ARADDR_I[7:2];

  always_comb
  begin
    case (awidx_q)
      `RCC_IDX_CHANNEL_NUMBER, `RCC_IDX_SYNC, `RCC_IDX_MODEM, `RCC_IDX_MANT,
      `RCC_IDX_AFTX, `RCC_IDX_CALPWR, `RCC_IDX_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write address and data capture, either order
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awidx_q <= 6'h00;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      S_AXI_AWREADY_O <= ~aw_held_d;
      S_AXI_WREADY_O <= ~w_held_d;
      if (aw_hs)
        awidx_q <= S_AXI_AWADDR_I[7:2];
      if (w_hs)
      begin
        wbyte_q <= S_AXI_WDATA_I[7:0];
        wstrb0_q <= S_AXI_WSTRB_I[0];
      end
    end
  end

  // write response
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `RCC_RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= wr_hit ? `RCC_RESP_OKAY : `RCC_RESP_SLVERR;
    end
    else if (S_AXI_BREADY_I)
      S_AXI_BVALID_O <= 1'b0;
  end

  // configuration that is lost in sleep
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      channel_number_q <= `RCC_RST_CHANNEL_NUMBER;
      sync_sel_q <= `RCC_RST_SYNC;
      spacing_exponent_q <= `RCC_RST_EXP;
      spacing_mantissa_q <= `RCC_RST_MANT;
      after_transmit_state_q <= `RCC_RST_AFTX;
      auto_cal_select_q <= `RCC_RST_AUTOCAL;
    end
    else if (state_q == RCC_ST_SLEEP)
    begin
      channel_number_q <= `RCC_RST_CHANNEL_NUMBER;
      sync_sel_q <= `RCC_RST_SYNC;
      spacing_exponent_q <= `RCC_RST_EXP;
      spacing_mantissa_q <= `RCC_RST_MANT;
      after_transmit_state_q <= `RCC_RST_AFTX;
      auto_cal_select_q <= `RCC_RST_AUTOCAL;
    end
    else if (do_write && wstrb0_q)
    begin
      case (awidx_q)
        `RCC_IDX_CHANNEL_NUMBER: channel_number_q <= wbyte_q;
        `RCC_IDX_SYNC: sync_sel_q <= wbyte_q[`RCC_SYNC_LSB +: 3];
        `RCC_IDX_MODEM: spacing_exponent_q <= wbyte_q[`RCC_EXP_LSB +: 2];
        `RCC_IDX_MANT: spacing_mantissa_q <= wbyte_q;
        `RCC_IDX_AFTX: after_transmit_state_q <= wbyte_q[`RCC_AFTX_LSB +: 2];
        `RCC_IDX_CALPWR: auto_cal_select_q <= wbyte_q[`RCC_AUTOCAL_LSB +: 2];
        default: ;
      endcase
    end
  end

  // power-up wait count kept through sleep
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      powerup_wait_count_q <= `RCC_RST_PWRUP;
    else if (do_write && wstrb0_q && awidx_q == `RCC_IDX_CALPWR)
      powerup_wait_count_q <= wbyte_q[`RCC_PWRUP_LSB +: 2];
  end

  // read path
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= `RCC_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY_O <= ~rvalid_d;
      S_AXI_RVALID_O <= rvalid_d;
      if (ar_hs)
      begin
        S_AXI_RDATA_O <= 32'h0000_0000;
        S_AXI_RRESP_O <= `RCC_RESP_OKAY;
        case (aridx)
          `RCC_IDX_CHANNEL_NUMBER: S_AXI_RDATA_O[7:0] <= channel_number_q;
          `RCC_IDX_SYNC: S_AXI_RDATA_O[`RCC_SYNC_LSB +: 3] <= sync_sel_q;
          `RCC_IDX_MODEM: S_AXI_RDATA_O[`RCC_EXP_LSB +: 2] <= spacing_exponent_q;
          `RCC_IDX_MANT: S_AXI_RDATA_O[7:0] <= spacing_mantissa_q;
          `RCC_IDX_AFTX: S_AXI_RDATA_O[`RCC_AFTX_LSB +: 2] <= after_transmit_state_q;
          `RCC_IDX_CALPWR:
          begin
            S_AXI_RDATA_O[`RCC_AUTOCAL_LSB +: 2] <= auto_cal_select_q;
            S_AXI_RDATA_O[`RCC_PWRUP_LSB +: 2] <= powerup_wait_count_q;
          end
          `RCC_IDX_STATUS:
          begin
            S_AXI_RDATA_O[`RCC_ST_STATE_LSB +: 3] <= state_q;
            S_AXI_RDATA_O[`RCC_ST_READY_BIT] <= ~CHIP_READY_N_O;
            S_AXI_RDATA_O[`RCC_ST_CALCNT_LSB +: 2] <= tx_idle_cnt_q;
          end
          default: S_AXI_RRESP_O <= `RCC_RESP_SLVERR;
        endcase
      end
    end
  end

  // calibration on the way back from transmit to idle
  always_comb
  begin
    case (auto_cal_select_q)
      2'h2: cal_on_exit = 1'b1;
      2'h3: cal_on_exit = tx_idle_cnt_q == 2'h3;
      default: cal_on_exit = 1'b0;
    endcase
  end

  // radio state sequencing
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_q <= RCC_ST_IDLE;
      cal_ret_q <= RCC_ST_IDLE;
      tx_idle_cnt_q <= 2'h0;
      CAL_START_O <= 1'b0;
      PREAMBLE_START_O <= 1'b0;
    end
    else
    begin
      CAL_START_O <= 1'b0;
      PREAMBLE_START_O <= 1'b0;
      case (state_q)
        RCC_ST_IDLE:
          if (SLEEP_I)
            state_q <= RCC_ST_SLEEP;
          else if (CALIBRATE_STROBE_I)
          begin
            state_q <= RCC_ST_CAL;
            cal_ret_q <= RCC_ST_IDLE;
            CAL_START_O <= 1'b1;
          end
          else if (TX_START_I || SYNTH_ON_I)
          begin
            if (auto_cal_select_q == 2'h1)
            begin
              state_q <= RCC_ST_CAL;
              cal_ret_q <= TX_START_I ? RCC_ST_TX : RCC_ST_SYNTH_ON;
              CAL_START_O <= 1'b1;
            end
            else
              state_q <= TX_START_I ? RCC_ST_TX : RCC_ST_SYNTH_ON;
          end
        RCC_ST_CAL:
          if (CAL_DONE_I)
            state_q <= cal_ret_q;
        RCC_ST_SYNTH_ON:
          if (TX_START_I)
            state_q <= RCC_ST_TX;
          else if (IDLE_I)
            state_q <= RCC_ST_IDLE;
        RCC_ST_TX:
          if (IDLE_I || (PKT_DONE_I && after_transmit_state_q[1] == 1'b0 &&
                         after_transmit_state_q[0] == 1'b0))
          begin
            tx_idle_cnt_q <= tx_idle_cnt_q + 2'h1;
            if (cal_on_exit)
            begin
              state_q <= RCC_ST_CAL;
              cal_ret_q <= RCC_ST_IDLE;
              CAL_START_O <= 1'b1;
            end
            else
              state_q <= RCC_ST_IDLE;
          end
          else if (PKT_DONE_I)
          begin
            case (after_transmit_state_q)
              2'h1: state_q <= RCC_ST_SYNTH_ON;
              2'h2: PREAMBLE_START_O <= 1'b1;
              default: state_q <= RCC_ST_IDLE;
            endcase
          end
        RCC_ST_SLEEP:
          if (!SLEEP_I)
            state_q <= RCC_ST_IDLE;
        default: state_q <= RCC_ST_IDLE;
      endcase
    end
  end

  rcc_powerup_timer #(
    .RIPPLE_BITS(RIPPLE_BITS)
  ) u_pwr (
    .clk_i(REF_CLK_I),
    .rst_n_i(NRST_I),
    .osc_ok_i(CRYSTAL_OSCILLATOR_STABLE_I && state_q != RCC_ST_SLEEP),
    .sel_i(powerup_wait_count_q),
    .done_o(pwr_done)
  );

  rcc_sync_decode u_sync (
    .sel_i(sync_sel_q),
    .qual_o(qual),
    .cs_en_o(cs_en),
    .txsync_o(txsync)
  );

  assign base_prod = ({`RCC_MANT_LEAD} | {1'b0, spacing_mantissa_q}) * channel_number_q;
  assign offset = {3'b000, base_prod} << spacing_exponent_q;

  // registered outputs
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      CHIP_READY_N_O <= 1'b1;
      CHANNEL_OFFSET_O <= 20'h0_0000;
      SYNC_QUAL_O <= RCC_QUAL_NONE;
      SYNC_CS_EN_O <= 1'b0;
      TX_SYNC_O <= RCC_TXSYNC_NONE;
    end
    else
    begin
      CHIP_READY_N_O <= ~pwr_done;
      CHANNEL_OFFSET_O <= offset;
      SYNC_QUAL_O <= qual;
      SYNC_CS_EN_O <= cs_en;
      TX_SYNC_O <= txsync;
    end
  end

  assign STATE_O = state_q;

endmodule
`default_nettype wire
